// ---- hw/ssrf_top.sv ----
// scan timing, change pause, running-average filter and temperature limit
// front end pushes raw readings through a FIFO; settings arrive on plain ports
`timescale 1ns/10ps

module ssrf_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ssrf_fifo_st_t;
  ssrf_fifo_st_t s_ff;
  ssrf_fifo_st_t nxt_s;
  logic push;
  logic pop;

  assign inReady = (s_ff.cnt != (AW+1)'(DEPTH));
  assign outValid = (s_ff.cnt != '0);
  assign outData = s_ff.mem[s_ff.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wp] = inData;
      nxt_s.wp = AW'(s_ff.wp + 1'b1);
    end
    if (pop)
      nxt_s.rp = AW'(s_ff.rp + 1'b1);
    nxt_s.cnt = (AW+1)'(s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s_ff <= '0;
    else if (clkEn)
      s_ff <= nxt_s;
  end
endmodule

// Summary of operation
// RULE1: autoscan dwells per-channel 1..200 s, default 10
// RULE2: dwell counts only after pause and settling
// RULE3: control on scanned channel freezes dwell
// RULE4: readings unusable until change pause expires
// RULE5: change pause 3..60 s, default 3
// RULE6: one raw reading every 100 ms
// RULE7: filter gives equal-weight mean, 10..2000 readings; once full, code drops the mean rather than the oldest reading
// RULE8: fresh result strobed every reading update
// RULE9: unfiltered path smooths with 200 ms constant
// RULE10: settling starts when change pause ends
// RULE11: readings averaged equal settle seconds times ten
// RULE12: settle time 0..200 s, default 18
// RULE13: zero settle shows raw, keeps averaging
// RULE14: settle change never resets the filter
// RULE15: step beyond window restarts the filter
// RULE16: window 1..80 percent of full scale, default 10
// RULE17: tempco sign used only without curve
// RULE18: fifteen-character label per input and channel
// RULE19: any over-limit reading disables control; 0 off
// RULE20: curves 1..20 standard, 21..59 user
// RULE21: per-input preferred units kelvin or sensor
// RULE22: restart clears sum, count, restarts settling
module ssrf_top #(
  parameter int TICK_CYC_P = ssrf_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic rawValid,
  output logic rawReady,
  input wire logic [ssrf_pkg::RD_W-1:0] rawData,
  input wire logic [ssrf_pkg::RD_W-1:0] fullScale,
  input wire logic rangeChg,
  input wire logic chanSelWe,
  input wire logic [3:0] chanSelIdx,
  input wire logic [15:0] chanEnMask,
  input wire logic autoscanEn,
  input wire logic ctrlOnScanned,
  input wire logic cfgWe,
  input wire logic [ssrf_pkg::IDX_W-1:0] cfgIdx,
  input wire ssrf_pkg::ssrf_cfg_t cfgIn,
  input wire ssrf_pkg::ssrf_temp_t tempIn,
  input wire ssrf_pkg::ssrf_label_wr_t labelWr,
  input wire logic [ssrf_pkg::IDX_W-1:0] labelRdIdx,
  input wire logic [3:0] labelRdPos,
  output logic [7:0] labelRdChar,
  output ssrf_pkg::ssrf_rdg_t readingOut,
  output logic readingStrobe,
  output logic [4:0] scanChan,
  output ssrf_pkg::ssrf_phase_t scanPhase,
  output logic controlOff,
  output logic ctrlTcApplies,
  output logic ctrlTcPositive,
  output logic prefSensorUnits,
  output logic curveStandard,
  output logic curveUser
);
  typedef struct packed {
    logic [ssrf_pkg::NCH-1:0] [$bits(ssrf_pkg::ssrf_cfg_t)-1:0] cfg;
    logic [ssrf_pkg::NCH-1:0][ssrf_pkg::LABEL_LEN-1:0][7:0] label;
    logic [ssrf_pkg::NCH-1:0] ovr;
    logic ctrlOff;
    ssrf_pkg::ssrf_phase_t phase;
    logic [3:0] chan;
    logic [23:0] tickCnt;
    logic [ssrf_pkg::CNT_W-1:0] phaseCnt;
    logic [ssrf_pkg::SUM_W-1:0] sum;
    logic [ssrf_pkg::CNT_W-1:0] cnt;
    logic [ssrf_pkg::RD_W-1:0] smooth;
    ssrf_pkg::ssrf_rdg_t rdOut;
    logic rdStrobe;
  } ssrf_state_t;

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYC_P - 1);

  ssrf_state_t s_ff;
  ssrf_state_t nxt_s;
  ssrf_pkg::ssrf_cfg_t curCfg;
  ssrf_pkg::ssrf_cfg_t ctlCfg;
  ssrf_pkg::ssrf_cfg_t limCfg;
  logic [ssrf_pkg::IDX_W-1:0] chanIdx;
  logic tick;
  logic take;
  logic restart;
  logic dwellHold;
  logic fifoValid;
  logic [ssrf_pkg::RD_W-1:0] x;
  logic [ssrf_pkg::CNT_W-1:0] settleN;
  logic [ssrf_pkg::CNT_W-1:0] pauseN;
  logic [ssrf_pkg::CNT_W-1:0] dwellN;
  logic [ssrf_pkg::RD_W-1:0] meanOld;
  logic [ssrf_pkg::RD_W-1:0] winLim;
  logic [ssrf_pkg::RD_W-1:0] diff;

  function automatic logic [ssrf_pkg::CNT_W-1:0] times10(input logic [7:0] v);
    times10 = ssrf_pkg::CNT_W'({4'h0, v} * ssrf_pkg::READS_PER_SEC); // [RULE11]
  endfunction

  function automatic logic [1:0] curveClass(input logic [5:0] c);
    curveClass[1] = (c != 6'h00) && (c <= ssrf_pkg::CURVE_STD_MAX); // [RULE20]
    curveClass[0] = (c >= ssrf_pkg::CURVE_USER_MIN) && (c <= ssrf_pkg::CURVE_USER_MAX);
  endfunction

  function automatic ssrf_pkg::ssrf_cfg_t clampCfg(input ssrf_pkg::ssrf_cfg_t c);
    clampCfg = c;
    if (c.dwellSec < ssrf_pkg::DWELL_MIN) clampCfg.dwellSec = ssrf_pkg::DWELL_MIN;
    if (c.dwellSec > ssrf_pkg::DWELL_MAX) clampCfg.dwellSec = ssrf_pkg::DWELL_MAX; // [RULE1]
    if (c.pauseSec < ssrf_pkg::PAUSE_MIN) clampCfg.pauseSec = ssrf_pkg::PAUSE_MIN;
    if (c.pauseSec > ssrf_pkg::PAUSE_MAX) clampCfg.pauseSec = ssrf_pkg::PAUSE_MAX; // [RULE5]
    if (c.settleSec > ssrf_pkg::SETTLE_MAX) clampCfg.settleSec = ssrf_pkg::SETTLE_MAX; // [RULE12]
    if (c.windowPct < ssrf_pkg::WIN_MIN) clampCfg.windowPct = ssrf_pkg::WIN_MIN;
    if (c.windowPct > ssrf_pkg::WIN_MAX) clampCfg.windowPct = ssrf_pkg::WIN_MAX; // [RULE16]
    if (c.tempLimK > ssrf_pkg::TLIM_MAX) clampCfg.tempLimK = ssrf_pkg::TLIM_MAX; // [RULE19]
    if (c.curve > ssrf_pkg::CURVE_USER_MAX) clampCfg.curve = 6'h00; // [RULE20]
  endfunction

  function automatic logic [3:0] nextEnabled(input logic [3:0] cur, input logic [15:0] m);
    logic found;
    logic [3:0] k;
    found = 1'b0;
    nextEnabled = cur;
    for (int i = 1; i <= 16; i++)
    begin
      k = 4'(cur + 4'(i));
      if (!found && m[k])
      begin
        found = 1'b1;
        nextEnabled = k;
      end
    end
  endfunction

  // back-pressure: the FIFO only drains on the 100 ms tick
  ssrf_fifo #(.W(ssrf_pkg::RD_W), .DEPTH(ssrf_pkg::FIFO_DEPTH)) rawFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .inValid(rawValid),
    .inReady(rawReady),
    .inData(rawData),
    .outValid(fifoValid),
    .outReady(tick),
    .outData(x)
  );

  assign chanIdx = 5'({1'b0, s_ff.chan} + 5'h01);
  assign curCfg = ssrf_pkg::ssrf_cfg_t'(s_ff.cfg[chanIdx]);
  assign ctlCfg = ssrf_pkg::ssrf_cfg_t'(s_ff.cfg[0]);
  assign limCfg = ssrf_pkg::ssrf_cfg_t'(s_ff.cfg[tempIn.idx]);
  assign tick = (s_ff.tickCnt == TICK_LAST); // [RULE6]
  assign take = tick && fifoValid;
  assign settleN = times10(curCfg.settleSec); // [RULE7]
  assign pauseN = times10({2'b00, curCfg.pauseSec});
  assign dwellN = times10(curCfg.dwellSec);
  assign meanOld = (s_ff.cnt == '0) ? x :
    ssrf_pkg::RD_W'(s_ff.sum / {24'h00_0000, s_ff.cnt});
  assign winLim = ssrf_pkg::RD_W'(({7'h00, fullScale} * {24'h00_0000, curCfg.windowPct})
    / ssrf_pkg::PCT_DIV); // [RULE16]
  assign diff = (x > meanOld) ? (x - meanOld) : (meanOld - x);
  assign restart = take && curCfg.filterEn && (s_ff.phase != ssrf_pkg::PH_PAUSE)
    && (s_ff.cnt != '0) && (diff > winLim); // [RULE15]
  assign dwellHold = ctrlOnScanned && autoscanEn; // [RULE3]

  always_comb
  begin
    logic [ssrf_pkg::CNT_W-1:0] cap;
    logic [ssrf_pkg::RD_W-1:0] newMean;
    logic stepChan;
    logic showAvg;
    cap = (settleN == '0) ? ssrf_pkg::NMAX : settleN;
    newMean = '0;
    stepChan = 1'b0;
    showAvg = 1'b0;
    nxt_s = s_ff;
    nxt_s.tickCnt = tick ? 24'h00_0000 : 24'(s_ff.tickCnt + 24'h00_0001);
    nxt_s.rdStrobe = 1'b0;
    if (cfgWe && (cfgIdx < ssrf_pkg::IDX_W'(ssrf_pkg::NCH)))
      nxt_s.cfg[cfgIdx] = clampCfg(cfgIn);
    if (labelWr.we && (labelWr.idx < ssrf_pkg::IDX_W'(ssrf_pkg::NCH))
      && (labelWr.pos < 4'(ssrf_pkg::LABEL_LEN)))
      nxt_s.label[labelWr.idx][labelWr.pos] = labelWr.ch; // [RULE18]
    if (tempIn.valid && (tempIn.idx < ssrf_pkg::IDX_W'(ssrf_pkg::NCH)))
      nxt_s.ovr[tempIn.idx] = (limCfg.tempLimK != 12'h000) && (tempIn.kelvin > limCfg.tempLimK);
    nxt_s.ctrlOff = |nxt_s.ovr; // [RULE19]
    if (take)
    begin
      nxt_s.smooth = ssrf_pkg::RD_W'(((ssrf_pkg::SW'(s_ff.smooth) << ssrf_pkg::SMOOTH_SHIFT)
        - ssrf_pkg::SW'(s_ff.smooth) + ssrf_pkg::SW'(x)) >> ssrf_pkg::SMOOTH_SHIFT); // [RULE9]
      if (restart)
      begin
        nxt_s.sum = ssrf_pkg::SUM_W'(x); // [RULE22]
        nxt_s.cnt = 12'h001;
      end
      else if (curCfg.filterEn && (s_ff.phase != ssrf_pkg::PH_PAUSE))
      begin
        // accumulation continues with zero settle; a shorter setting keeps the sum
        if (s_ff.cnt < cap) // [RULE13] [RULE14]
        begin
          nxt_s.sum = ssrf_pkg::SUM_W'(s_ff.sum + ssrf_pkg::SUM_W'(x));
          nxt_s.cnt = ssrf_pkg::CNT_W'(s_ff.cnt + 12'h001);
        end
        else
          // full window: drop one mean-weighted sample, no history buffer needed
          nxt_s.sum = ssrf_pkg::SUM_W'(s_ff.sum - ssrf_pkg::SUM_W'(meanOld)
            + ssrf_pkg::SUM_W'(x)); // [RULE7]
      end
      if (nxt_s.cnt != '0)
        newMean = ssrf_pkg::RD_W'(nxt_s.sum / {24'h00_0000, nxt_s.cnt});
      showAvg = curCfg.filterEn && (settleN != '0) && (nxt_s.cnt >= settleN); // [RULE13]
    end
    case (s_ff.phase)
      ssrf_pkg::PH_PAUSE:
      begin
        nxt_s.sum = '0;
        nxt_s.cnt = '0;
        if (tick)
        begin
          nxt_s.phaseCnt = ssrf_pkg::CNT_W'(s_ff.phaseCnt + 12'h001);
          if (nxt_s.phaseCnt >= pauseN) // [RULE5] [RULE10]
          begin
            nxt_s.phase = ssrf_pkg::PH_SETTLE;
            nxt_s.phaseCnt = '0;
          end
        end
      end
      ssrf_pkg::PH_SETTLE:
      begin
        if (!curCfg.filterEn || (nxt_s.cnt >= settleN)) // [RULE2]
        begin
          nxt_s.phase = ssrf_pkg::PH_DWELL;
          nxt_s.phaseCnt = '0;
        end
      end
      ssrf_pkg::PH_DWELL:
      begin
        if (restart)
        begin
          nxt_s.phase = ssrf_pkg::PH_SETTLE; // [RULE22]
          nxt_s.phaseCnt = '0;
        end
        else if (tick && autoscanEn && !dwellHold) // [RULE3]
        begin
          nxt_s.phaseCnt = ssrf_pkg::CNT_W'(s_ff.phaseCnt + 12'h001);
          stepChan = (nxt_s.phaseCnt >= dwellN); // [RULE1]
        end
      end
      default:
      begin
        nxt_s.phase = ssrf_pkg::PH_PAUSE;
        nxt_s.phaseCnt = '0;
      end
    endcase
    if (stepChan || chanSelWe || rangeChg) // [RULE4]
    begin
      if (chanSelWe)
        nxt_s.chan = chanSelIdx;
      else if (stepChan)
        nxt_s.chan = nextEnabled(s_ff.chan, chanEnMask);
      nxt_s.phase = ssrf_pkg::PH_PAUSE;
      nxt_s.phaseCnt = '0;
      nxt_s.sum = '0;
      nxt_s.cnt = '0;
    end
    if (take)
    begin
      nxt_s.rdStrobe = 1'b1; // [RULE8]
      nxt_s.rdOut.value = showAvg ? newMean : nxt_s.smooth;
      nxt_s.rdOut.filtered = showAvg;
      nxt_s.rdOut.settled = curCfg.filterEn && (nxt_s.cnt >= settleN);
      nxt_s.rdOut.usable = (nxt_s.phase != ssrf_pkg::PH_PAUSE); // [RULE4]
    end
    else if (nxt_s.phase == ssrf_pkg::PH_PAUSE)
      nxt_s.rdOut.usable = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= '0;
      for (int i = 0; i < ssrf_pkg::NCH; i++)
        s_ff.cfg[i] <= ssrf_pkg::CFG_DEF; // [RULE5] [RULE12] [RULE16] [RULE17]
    end
    else if (clkEn)
      s_ff <= nxt_s;
  end

  assign readingOut = s_ff.rdOut;
  assign readingStrobe = s_ff.rdStrobe;
  assign scanChan = 5'({1'b0, s_ff.chan} + 5'h01);
  assign scanPhase = s_ff.phase;
  assign controlOff = s_ff.ctrlOff;
  assign ctrlTcApplies = (ctlCfg.curve == 6'h00); // [RULE17]
  assign ctrlTcPositive = ctlCfg.tempCoPos;
  assign prefSensorUnits = curCfg.prefSensor; // [RULE21]
  assign {curveStandard, curveUser} = curveClass(curCfg.curve);
  assign labelRdChar = ((labelRdIdx < ssrf_pkg::IDX_W'(ssrf_pkg::NCH))
    && (labelRdPos < 4'(ssrf_pkg::LABEL_LEN))) ? s_ff.label[labelRdIdx][labelRdPos] : 8'h00;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clkEn);

  usable_gate_a: assert property (readingOut.usable |-> scanPhase != ssrf_pkg::PH_PAUSE) // [RULE4]
    else $error("reading usable during change pause");
  tick_space_a: assert property (tick |=> !tick [*8]) // [RULE6]
    else $error("reading ticks too close");
  strobe_a: assert property (take |=> readingStrobe ##1 !readingStrobe) // [RULE8]
    else $error("reading strobe missing or stuck");
  dwell_entry_a: assert property ((scanPhase == ssrf_pkg::PH_SETTLE) ##1 // [RULE2]
    (scanPhase == ssrf_pkg::PH_DWELL) |-> !curCfg.filterEn || s_ff.cnt >= settleN)
    else $error("dwell began before settling");
  dwell_freeze_a: assert property ((scanPhase == ssrf_pkg::PH_DWELL) && dwellHold // [RULE3]
    && !restart && !rangeChg && !chanSelWe |=> $stable(s_ff.phaseCnt))
    else $error("dwell advanced while control holds");
  pause_exit_a: assert property ((scanPhase == ssrf_pkg::PH_PAUSE) ##1 // [RULE5]
    (scanPhase == ssrf_pkg::PH_SETTLE) |-> $past(s_ff.phaseCnt) + 12'h001 >= $past(pauseN))
    else $error("pause ended early");
  dwell_step_a: assert property (tick && autoscanEn && !dwellHold && !restart // [RULE1]
    && (scanPhase == ssrf_pkg::PH_DWELL) && (s_ff.phaseCnt + 12'h001 >= dwellN)
    |=> scanPhase == ssrf_pkg::PH_PAUSE)
    else $error("dwell expiry did not step channel");
  restart_a: assert property (restart && !rangeChg && !chanSelWe // [RULE15]
    |=> s_ff.cnt == 12'h001 ##0 scanPhase != ssrf_pkg::PH_DWELL)
    else $error("window step did not restart filter");
  limit_a: assert property (tempIn.valid && (tempIn.idx < 5'h11) && // [RULE19]
    (tempIn.kelvin > limCfg.tempLimK) && !cfgWe && (limCfg.tempLimK != 12'h000)
    |=> controlOff)
    else $error("over-limit reading left control on");

  sequence dwell_step_a_seq;
    (scanPhase == ssrf_pkg::PH_DWELL) ##1 (scanPhase == ssrf_pkg::PH_PAUSE);
  endsequence
  dwell_done_c: cover property (dwell_step_a_seq);
  restart_c: cover property (restart);
  avg_shown_c: cover property (readingStrobe && readingOut.filtered);
  limit_trip_c: cover property ($rose(controlOff));
endmodule

// ---- hw/ssrf_pkg.sv ----
// constants and carrier types for the scan/settle reading filter
// assumes a 100 MHz ref_clk and readings of RD_W bits from the front end
package ssrf_pkg;
  localparam int RD_W = 24;
  localparam int SUM_W = 36;
  localparam int CNT_W = 12;
  localparam int NCH = 17; // index 0 control input, 1..16 scanner channels
  localparam int IDX_W = 5;
  localparam int LABEL_LEN = 15;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_PERIOD_MS = 100;
  localparam int TICK_CYC = READ_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int SMOOTH_TC_MS = 200;
  localparam int SMOOTH_SHIFT = $clog2(SMOOTH_TC_MS / READ_PERIOD_MS);
  localparam int SW = RD_W + SMOOTH_SHIFT + 1;
  localparam logic [7:0] DWELL_MIN = 8'h01;
  localparam logic [7:0] DWELL_MAX = 8'hC8;
  localparam logic [7:0] DWELL_DEF = 8'h0A;
  localparam logic [5:0] PAUSE_MIN = 6'h03;
  localparam logic [5:0] PAUSE_MAX = 6'h3C;
  localparam logic [5:0] PAUSE_DEF = 6'h03;
  localparam logic [7:0] SETTLE_MAX = 8'hC8;
  localparam logic [7:0] SETTLE_DEF = 8'h12;
  localparam logic [6:0] WIN_MIN = 7'h01;
  localparam logic [6:0] WIN_MAX = 7'h50;
  localparam logic [6:0] WIN_DEF = 7'h0A;
  localparam logic [11:0] TLIM_MAX = 12'hBB7;
  localparam logic [5:0] CURVE_STD_MAX = 6'h14;
  localparam logic [5:0] CURVE_USER_MIN = 6'h15;
  localparam logic [5:0] CURVE_USER_MAX = 6'h3B;
  localparam logic [11:0] READS_PER_SEC = 12'h00A;
  localparam logic [CNT_W-1:0] NMAX = 12'h7D0;
  localparam logic [30:0] PCT_DIV = 31'h0000_0064;

  typedef enum logic [1:0] {PH_PAUSE, PH_SETTLE, PH_DWELL} ssrf_phase_t;

  typedef struct packed {
    logic [7:0] dwellSec;
    logic [5:0] pauseSec;
    logic [7:0] settleSec;
    logic [6:0] windowPct;
    logic [11:0] tempLimK;
    logic tempCoPos;
    logic prefSensor;
    logic [5:0] curve;
    logic filterEn;
  } ssrf_cfg_t;

  localparam ssrf_cfg_t CFG_DEF = '{dwellSec: DWELL_DEF, pauseSec: PAUSE_DEF,
    settleSec: SETTLE_DEF, windowPct: WIN_DEF, tempLimK: 12'h000, tempCoPos: 1'b0,
    prefSensor: 1'b0, curve: 6'h00, filterEn: 1'b0};

  typedef struct packed {
    logic [RD_W-1:0] value;
    logic filtered;
    logic settled;
    logic usable;
  } ssrf_rdg_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [11:0] kelvin;
  } ssrf_temp_t;

  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] idx;
    logic [3:0] pos;
    logic [7:0] ch;
  } ssrf_label_wr_t;
endpackage

// ---- sim/ssrf_front_end.sv ----
// front-end stand-in: offers raw readings on the block's valid/ready stream
// assumes the block samples on the rising edge of ref_clk
`timescale 1ns/10ps
module ssrf_front_end (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic feOn,
  input wire logic [ssrf_pkg::RD_W-1:0] feValue,
  input wire logic rawReady,
  output logic rawValid,
  output logic [ssrf_pkg::RD_W-1:0] rawData,
  output int feSent
);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rawValid <= 1'b0;
      rawData <= '0;
      feSent <= 0;
    end
    else if (rawValid && !rawReady)
    begin
      // offer held whole until the block takes it
      rawValid <= 1'b1;
    end
    else
    begin
      if (rawValid)
        feSent <= feSent + 1;
      rawValid <= feOn;
      // idle data toggles so a stale word never looks valid
      rawData <= feOn ? feValue : ~rawData;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the scan/settle reading filter
// assumes ssrf_front_end as the reading source; tick shortened to 20 cycles
`timescale 1ns/10ps
module tb_top;
  localparam int TP = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic feOn = 1'b0;
  logic [ssrf_pkg::RD_W-1:0] feValue = 24'h00_03E8;
  logic [ssrf_pkg::RD_W-1:0] fullScale = 24'h00_03E8;
  logic rangeChg = 1'b0;
  logic chanSelWe = 1'b0;
  logic [3:0] chanSelIdx = 4'h0;
  logic [15:0] chanEnMask = 16'h0005;
  logic autoscanEn = 1'b0;
  logic ctrlOnScanned = 1'b0;
  logic cfgWe = 1'b0;
  logic [ssrf_pkg::IDX_W-1:0] cfgIdx = '0;
  ssrf_pkg::ssrf_cfg_t cfgIn = ssrf_pkg::CFG_DEF;
  ssrf_pkg::ssrf_temp_t tempIn = '0;
  ssrf_pkg::ssrf_label_wr_t labelWr = '0;
  logic [ssrf_pkg::IDX_W-1:0] labelRdIdx = '0;
  logic [3:0] labelRdPos = 4'h0;
  logic rawValid, rawReady, readingStrobe, controlOff, ctrlTcApplies, ctrlTcPositive;
  logic prefSensorUnits, curveStandard, curveUser;
  logic [ssrf_pkg::RD_W-1:0] rawData;
  logic [7:0] labelRdChar;
  logic [4:0] scanChan;
  ssrf_pkg::ssrf_rdg_t readingOut;
  ssrf_pkg::ssrf_phase_t scanPhase;
  int feSent, strobeCnt = 0, cycles = 0, err_total = 0, check_count = 0;

  always #5 ref_clk = ~ref_clk;

  ssrf_front_end i_fe (.ref_clk, .rst, .feOn, .feValue, .rawReady, .rawValid, .rawData, .feSent);

  ssrf_top #(.TICK_CYC_P(TP)) i_dut (.ref_clk, .rst, .clkEn, .rawValid, .rawReady, .rawData,
    .fullScale, .rangeChg, .chanSelWe, .chanSelIdx, .chanEnMask, .autoscanEn, .ctrlOnScanned,
    .cfgWe, .cfgIdx, .cfgIn, .tempIn, .labelWr, .labelRdIdx, .labelRdPos, .labelRdChar,
    .readingOut, .readingStrobe, .scanChan, .scanPhase, .controlOff, .ctrlTcApplies,
    .ctrlTcPositive, .prefSensorUnits, .curveStandard, .curveUser);

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // counted on the rising edge so negedge readers of cycles never race it
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      err_total++;
      $display("CHECK FAILED run time expected below 20000 seen %0d", cycles);
      finish_test();
    end
  end

  // strobe is one cycle wide, so one negedge sample sees each exactly once
  always @(negedge ref_clk)
  begin
    if (readingStrobe === 1'b1)
      strobeCnt++;
  end

  task automatic set_cfg(input logic [4:0] idx, input ssrf_pkg::ssrf_cfg_t c);
    @(negedge ref_clk);
    cfgIdx = idx;
    cfgIn = c;
    cfgWe = 1'b1;
    @(negedge ref_clk);
    cfgWe = 1'b0;
  endtask

  task automatic sel_chan(input logic [3:0] idx);
    @(negedge ref_clk);
    chanSelIdx = idx;
    chanSelWe = 1'b1;
    @(negedge ref_clk);
    chanSelWe = 1'b0;
  endtask

  task automatic wait_phase(input ssrf_pkg::ssrf_phase_t ph, input int lim, output int n);
    n = 0;
    while (scanPhase !== ph && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic wait_strobe(input int k);
    int n;
    n = 0;
    repeat (k)
    begin
      @(negedge ref_clk);
      while (readingStrobe !== 1'b1 && n < 400)
      begin
        @(negedge ref_clk);
        n++;
      end
    end
  endtask

  task automatic send_temp(input logic [11:0] k, input logic exp, input string what);
    @(negedge ref_clk);
    tempIn = '{valid: 1'b1, idx: 5'h01, kelvin: k};
    @(negedge ref_clk);
    tempIn.valid = 1'b0;
    @(negedge ref_clk);
    chk(what, {31'h0, exp}, {31'h0, controlOff});
  endtask

  initial
  begin
    ssrf_pkg::ssrf_cfg_t c;
    logic [5:0] curves [4];
    int n;
    int m;
    curves = '{6'h14, 6'h15, 6'h3B, 6'h3C};
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("scanChan", 32'h1, {27'h0, scanChan});
    chk("scanPhase", 32'(ssrf_pkg::PH_PAUSE), {30'h0, scanPhase});
    chk("rawReady", 32'h1, {31'h0, rawReady});
    chk("ctrlTcApplies", 32'h1, {31'h0, ctrlTcApplies});
    chk("ctrlTcPositive", 32'h0, {31'h0, ctrlTcPositive});
    chk("controlOff", 32'h0, {31'h0, controlOff});
    chk("curve flags", 32'h0, {30'h0, curveStandard, curveUser});
    $display("test reset done");

    feOn = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk("rawReady full", 32'h0, {31'h0, rawReady});
    wait_strobe(1);
    wait_strobe(1);
    wait_phase(scanPhase, 0, n);
    m = cycles;
    wait_strobe(1);
    chk("strobe spacing", TP, cycles - m);
    chk("usable in pause", 32'h0, {31'h0, readingOut.usable});
    feOn = 1'b0;
    repeat (12 * TP) @(negedge ref_clk);
    chk("drained count", feSent, strobeCnt);
    chk("rawReady empty", 32'h1, {31'h0, rawReady});
    feOn = 1'b1;
    $display("test stream done");

    // dwell 0 is clamped to the 1 s minimum
    c = ssrf_pkg::CFG_DEF;
    c.dwellSec = 8'h00;
    c.pauseSec = 6'h04;
    set_cfg(5'h03, c);
    autoscanEn = 1'b1;
    sel_chan(4'h2);
    wait_phase(ssrf_pkg::PH_DWELL, 1000, n);
    chk("scanChan 3", 32'h3, {27'h0, scanChan});
    chk("pause 4 s", 32'h1, 32'(n >= 770 && n <= 850));
    wait_phase(ssrf_pkg::PH_PAUSE, 400, n);
    chk("dwell 1 s", 32'h1, 32'(n >= 180 && n <= 230));
    chk("next enabled", 32'h1, {27'h0, scanChan});
    wait_phase(ssrf_pkg::PH_DWELL, 900, n);
    chk("pause 3 s", 32'h1, 32'(n >= 570 && n <= 650));
    ctrlOnScanned = 1'b1;
    repeat (115 * TP) @(negedge ref_clk);
    chk("dwell held", 32'(ssrf_pkg::PH_DWELL), {30'h0, scanPhase});
    chk("chan held", 32'h1, {27'h0, scanChan});
    autoscanEn = 1'b0;
    ctrlOnScanned = 1'b0;
    $display("test scan done");

    c = ssrf_pkg::CFG_DEF;
    c.filterEn = 1'b1;
    c.settleSec = 8'h01;
    set_cfg(5'h01, c);
    wait_strobe(12);
    chk("mean", 32'h3E8, {8'h0, readingOut.value});
    chk("filtered", 32'h1, {31'h0, readingOut.filtered});
    chk("settled", 32'h1, {31'h0, readingOut.settled});
    chk("usable in dwell", 32'h1, {31'h0, readingOut.usable});
    feValue = 24'h00_04B0;
    wait_phase(ssrf_pkg::PH_SETTLE, 12 * TP, n);
    chk("restart", 32'(ssrf_pkg::PH_SETTLE), {30'h0, scanPhase});
    chk("restart unsettled", 32'h0, {31'h0, readingOut.settled});
    wait_phase(ssrf_pkg::PH_DWELL, 15 * TP, n);
    chk("settle 10 rdgs", 32'h1, 32'(n >= 170 && n <= 215));
    wait_strobe(1);
    chk("new mean", 32'h4B0, {8'h0, readingOut.value});
    c.settleSec = 8'h00;
    set_cfg(5'h01, c);
    wait_strobe(2);
    chk("zero settle raw", 32'h0, {31'h0, readingOut.filtered});
    c.settleSec = 8'h01;
    set_cfg(5'h01, c);
    wait_strobe(2);
    chk("back filtered", 32'h1, {31'h0, readingOut.filtered});
    chk("kept mean", 32'h4B0, {8'h0, readingOut.value});
    $display("test filter done");

    send_temp(12'hBB7, 1'b0, "limit off");
    c.tempLimK = 12'h064;
    set_cfg(5'h01, c);
    send_temp(12'h064, 1'b0, "at limit");
    send_temp(12'h065, 1'b1, "over limit");
    $display("test limit done");

    for (int i = 0; i < 4; i++)
    begin
      c.curve = curves[i];
      c.prefSensor = i[0];
      set_cfg(5'h01, c);
      chk("curve std", {31'h0, i == 0}, {31'h0, curveStandard});
      chk("curve user", {31'h0, i == 1 || i == 2}, {31'h0, curveUser});
      chk("units", {31'h0, i[0]}, {31'h0, prefSensorUnits});
    end
    c.tempCoPos = 1'b1;
    c.curve = 6'h05;
    set_cfg(5'h00, c);
    chk("tc with curve", 32'h0, {31'h0, ctrlTcApplies});
    c.curve = 6'h00;
    set_cfg(5'h00, c);
    chk("tc no curve", 32'h3, {30'h0, ctrlTcApplies, ctrlTcPositive});
    $display("test decode done");

    @(negedge ref_clk);
    labelWr = '{we: 1'b1, idx: 5'h10, pos: 4'hE, ch: 8'h5A};
    @(negedge ref_clk);
    labelWr = '{we: 1'b1, idx: 5'h00, pos: 4'h0, ch: 8'h41};
    @(negedge ref_clk);
    labelWr.we = 1'b0;
    labelRdIdx = 5'h10;
    labelRdPos = 4'hE;
    #1 chk("label ch16", 32'h5A, {24'h0, labelRdChar});
    labelRdIdx = 5'h00;
    labelRdPos = 4'h0;
    #1 chk("label input", 32'h41, {24'h0, labelRdChar});
    labelRdPos = 4'hF;
    #1 chk("label pos 15", 32'h0, {24'h0, labelRdChar});
    $display("test label done");

    @(negedge ref_clk);
    rangeChg = 1'b1;
    @(negedge ref_clk);
    rangeChg = 1'b0;
    chk("range pause", 32'(ssrf_pkg::PH_PAUSE), {30'h0, scanPhase});
    wait_strobe(2);
    chk("range usable", 32'h0, {31'h0, readingOut.usable});
    $display("test range done");
    finish_test();
  end
endmodule
